// ### flash_seq_pkg.sv
// Summary of operation
// - narrow start high: 8 bits, bits 19..16 used
// - narrow end high: 8 bits, bits 19..16 used
// - wide variant: 16-bit high, bits 31..25,20..16
// - error monitor captures failing address or block start
// - window start monitor: ones, then write buffer low
// - window end monitor: ones, then write buffer high
// - unique id: thirty-two read-only bytes
// - read buffers, ready flag, complete bit for reads
// - start-up protection lets blocks 0..15 be reprogrammed
// - self-programming limited to access window blocks
// - code reads continue during data-area operations
// - programmer and debugger gated by id code match
// - program, blank check, erase, uid read, extra commands
// - ready interrupt on command finish or forced stop
// ============================================================
// constants of the flash sequencer
// assumes an apb slave at byte addresses on a 32-bit bus
package flash_seq_pkg;
  localparam logic [7:0] off_start_low   = 8'h00;
  localparam logic [7:0] off_start_high  = 8'h04;
  localparam logic [7:0] off_end_low     = 8'h08;
  localparam logic [7:0] off_end_high    = 8'h0c;
  localparam logic [7:0] off_wbuf_low    = 8'h10;
  localparam logic [7:0] off_wbuf_high   = 8'h14;
  localparam logic [7:0] off_rbuf_low    = 8'h18;
  localparam logic [7:0] off_rbuf_high   = 8'h1c;
  localparam logic [7:0] off_cmd         = 8'h20;
  localparam logic [7:0] off_status      = 8'h24;
  localparam logic [7:0] off_err_low     = 8'h28;
  localparam logic [7:0] off_err_high    = 8'h2c;
  localparam logic [7:0] off_aw_start    = 8'h30;
  localparam logic [7:0] off_aw_end      = 8'h34;
  localparam logic [7:0] off_irq_status  = 8'h38;
  localparam logic [7:0] off_irq_mask    = 8'h3c;
  localparam logic [7:0] off_startup     = 8'h40;
  localparam logic [7:0] off_uid_base    = 8'h80;
  // command register fields
  localparam int cmd_code_lsb  = 0;
  localparam int cmd_start_bit = 4;
  localparam int cmd_stop_bit  = 5;
  localparam int cmd_rdc_bit   = 6;
  // status bits
  localparam int st_ready_bit = 0;
  localparam int st_rdrdy_bit = 1;
  localparam int st_err_bit   = 2;
  localparam int st_prot_bit  = 3;
  // irq bits
  localparam int irq_done_bit = 0;
  localparam int irq_err_bit  = 1;
  localparam logic [9:0] aw_blank    = 10'h3ff;
  localparam int         block_shift = 10;
  localparam int         startup_blocks = 16;
  localparam int         op_cycles_ns = 1000;
  localparam int         clk_ns = 100;
  localparam int         op_cycles = (op_cycles_ns + clk_ns - 1) / clk_ns;

  typedef enum logic [2:0] {
    cmd_program     = 3'h1,
    cmd_blank_check = 3'h2,
    cmd_block_erase = 3'h3,
    cmd_uid_read    = 3'h4,
    cmd_startup_prg = 3'h5,
    cmd_window_prg  = 3'h6
  } cmd_type;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_run   = 2'b01,
    st_wait  = 2'b10,
    st_done  = 2'b11
  } seq_type;
endpackage

// ### id_gate.sv
// ============================================================
// id code comparator for programmer and debugger connections
// assumes stored code and offered code are stable while compared
`timescale 1ns/100ps
module id_gate #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_nrst,
  // codes
  input  wire logic [W-1:0] i_stored,
  input  wire logic [W-1:0] i_offered,
  input  wire logic         i_request,
  // result
  output logic              o_granted
);
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_granted <= 1'b0;
    end else begin
      // grant lapses with the request so a later code change cannot inherit it
      o_granted <= i_request & (i_stored == i_offered);
    end
  end
endmodule

// ### pin_sync.sv
// ============================================================
// two-flop level synchroniser
// assumes the input is a slowly changing level
`timescale 1ns/100ps
module pin_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// ### flash_program_erase_sequencer.sv
// ============================================================
// flash program/erase sequencer with apb register file
// assumes a flash array port that accepts one word per strobe
`timescale 1ns/100ps
module flash_program_erase_sequencer #(
  parameter int WIDE = 0,
  parameter int IDW  = 32,
  parameter logic [IDW-1:0] ID_CODE = 32'h5a5a_0001 // arbitrary value
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  // apb
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // flash array
  output logic             o_fl_we,
  output logic             o_fl_erase,
  output logic [31:0]      o_fl_addr,
  output logic [31:0]      o_fl_wdata,
  input  wire logic [31:0] i_fl_rdata,
  input  wire logic        i_data_area,
  output logic             o_code_read_ok,
  // id gating
  input  wire logic        i_boot_mode,
  input  wire logic        i_dbg_req,
  input  wire logic [IDW-1:0] i_offered_id,
  output logic             o_conn_grant,
  // self-programming flag
  input  wire logic        i_self_prog,
  // interrupt
  output logic             o_irq
);
  localparam int HW = (WIDE != 0) ? 16 : 8;

  logic [15:0]    start_address_low;
  logic [HW-1:0]  start_address_high;
  logic [15:0]    end_address_low;
  logic [HW-1:0]  end_address_high;
  logic [15:0]    write_buffer_low;
  logic [15:0]    write_buffer_high;
  logic [15:0]    read_buffer_low;
  logic [15:0]    read_buffer_high;
  logic [15:0]    error_address_monitor_low;
  logic [HW-1:0]  error_address_monitor_high;
  logic [9:0]     access_window_start_monitor;
  logic [9:0]     access_window_end_monitor;
  logic           startup_setting_monitor;
  logic [2:0]     command_code;
  logic           read_ready_flag;
  logic           err_flag;
  logic           prot_flag;
  logic [1:0]     irq_status;
  logic [1:0]     irq_mask;
  logic [7:0]     uid_mem [0:31];
  flash_seq_pkg::seq_type state;
  logic [31:0]    cur_addr;
  logic [31:0]    end_addr;
  logic [3:0]     op_cnt;
  logic           wr_acc;
  logic           rd_acc;
  logic           go;
  logic           stop;
  logic           rd_done;
  logic           ev_done;
  logic           ev_err;
  logic           blocked;
  logic           fail;
  logic           self_prog_s;
  logic           boot_s;
  logic           dbg_s;
  logic [31:0]    next_rdata;

  // ============================================================
  // pins and id gate
  pin_sync u_sync_sp (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_self_prog), .o_sync(self_prog_s));
  pin_sync u_sync_bm (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_boot_mode), .o_sync(boot_s));
  pin_sync u_sync_db (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_dbg_req), .o_sync(dbg_s));

  id_gate #(.W(IDW)) u_gate (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_stored  (ID_CODE),
    .i_offered (i_offered_id),
    .i_request (boot_s | dbg_s),
    .o_granted (o_conn_grant)
  );

  // ============================================================
  // apb decode
  assign wr_acc    = i_psel & i_penable & i_pwrite;
  assign rd_acc    = i_psel & i_penable & ~i_pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  assign go      = wr_acc & (i_paddr == flash_seq_pkg::off_cmd) & i_pwdata[flash_seq_pkg::cmd_start_bit]
                   & (state == flash_seq_pkg::st_idle);
  assign stop    = wr_acc & (i_paddr == flash_seq_pkg::off_cmd) & i_pwdata[flash_seq_pkg::cmd_stop_bit];
  assign rd_done = wr_acc & (i_paddr == flash_seq_pkg::off_cmd) & i_pwdata[flash_seq_pkg::cmd_rdc_bit];

  // code area stays readable unless a code-area operation runs
  assign o_code_read_ok = (state == flash_seq_pkg::st_idle) | i_data_area;

  // ============================================================
  // address, write buffer and irq mask registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      start_address_low  <= 16'h0000;
      start_address_high <= '0;
      end_address_low    <= 16'h0000;
      end_address_high   <= '0;
      write_buffer_low   <= 16'h0000;
      write_buffer_high  <= 16'h0000;
      irq_mask           <= 2'h0;
    end else if (wr_acc && state == flash_seq_pkg::st_idle) begin
      unique case (i_paddr)
        flash_seq_pkg::off_start_low:  start_address_low  <= i_pwdata[15:0];
        flash_seq_pkg::off_end_low:    end_address_low    <= i_pwdata[15:0];
        // narrow keeps bits 19..16, wide keeps 31..25 and 20..16
        flash_seq_pkg::off_start_high: start_address_high <= (WIDE != 0) ? HW'(i_pwdata[15:0] & 16'hfe1f)
                                                                         : HW'(i_pwdata[3:0]);
        flash_seq_pkg::off_end_high:   end_address_high   <= (WIDE != 0) ? HW'(i_pwdata[15:0] & 16'hfe1f)
                                                                         : HW'(i_pwdata[3:0]);
        flash_seq_pkg::off_wbuf_low:   write_buffer_low   <= i_pwdata[15:0];
        flash_seq_pkg::off_wbuf_high:  write_buffer_high  <= i_pwdata[15:0];
        flash_seq_pkg::off_irq_mask:   irq_mask           <= i_pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ============================================================
  // command and protection
  function automatic logic [31:0] full_addr(input logic [HW-1:0] hi, input logic [15:0] lo);
    logic [15:0] h;
    // widen first so the wide-only selects stay in range for the narrow build
    h = 16'(hi);
    if (WIDE == 0) begin
      full_addr = {12'h000, h[3:0], lo};
    end else begin
      full_addr = {h[15:9], 4'h0, h[4:0], lo};
    end
  endfunction

  logic [9:0] cur_block;
  assign cur_block = cur_addr[flash_seq_pkg::block_shift +: 10];
  // startup-swap blocks 0..15 are always allowed once startup protect is set
  assign blocked = (command_code == flash_seq_pkg::cmd_program || command_code == flash_seq_pkg::cmd_block_erase)
                   & ~i_data_area
                   & ((self_prog_s & ((cur_block < access_window_start_monitor)
                                     | (cur_block >= access_window_end_monitor)))
                      & ~(startup_setting_monitor
                          & (cur_block < 10'(flash_seq_pkg::startup_blocks))));
  assign fail = (command_code == flash_seq_pkg::cmd_blank_check) & (i_fl_rdata != 32'hffff_ffff);

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      command_code <= 3'h0;
    end else if (go) begin
      command_code <= i_pwdata[flash_seq_pkg::cmd_code_lsb +: 3];
    end
  end

  // ============================================================
  // sequencer
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state    <= flash_seq_pkg::st_idle;
      cur_addr <= 32'h0;
      end_addr <= 32'h0;
      op_cnt   <= 4'h0;
    end else begin
      unique case (state)
        flash_seq_pkg::st_idle: begin
          if (go) begin
            cur_addr <= full_addr(start_address_high, start_address_low);
            end_addr <= full_addr(end_address_high, end_address_low);
            state    <= flash_seq_pkg::st_run;
          end
        end
        flash_seq_pkg::st_run: begin
          op_cnt <= 4'(flash_seq_pkg::op_cycles);
          if (stop || blocked || fail) begin
            state <= flash_seq_pkg::st_done;
          end else begin
            state <= flash_seq_pkg::st_wait;
          end
        end
        flash_seq_pkg::st_wait: begin
          if (stop) begin
            state <= flash_seq_pkg::st_done;
          end else if (op_cnt > 4'h1) begin
            op_cnt <= op_cnt - 4'h1;
          end else if (cur_addr >= end_addr || command_code == flash_seq_pkg::cmd_startup_prg
                       || command_code == flash_seq_pkg::cmd_window_prg) begin
            state <= flash_seq_pkg::st_done;
          end else begin
            cur_addr <= cur_addr + ((command_code == flash_seq_pkg::cmd_block_erase) ? 32'h400 : 32'h4);
            state    <= flash_seq_pkg::st_run;
          end
        end
        flash_seq_pkg::st_done: state <= flash_seq_pkg::st_idle;
      endcase
    end
  end

  assign ev_done = (state == flash_seq_pkg::st_done);
  assign ev_err  = (state == flash_seq_pkg::st_run) & (blocked | fail);
  // array address is the word flop itself, so blank-check data belongs to the current word
  assign o_fl_addr = cur_addr;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fl_we    <= 1'b0;
      o_fl_erase <= 1'b0;
      o_fl_wdata <= 32'h0;
    end else begin
      // blocked targets never strobe the array
      o_fl_we    <= (state == flash_seq_pkg::st_run) & ~blocked & ~stop
                    & (command_code == flash_seq_pkg::cmd_program);
      o_fl_erase <= (state == flash_seq_pkg::st_run) & ~blocked & ~stop
                    & (command_code == flash_seq_pkg::cmd_block_erase);
      o_fl_wdata <= {write_buffer_high, write_buffer_low};
    end
  end

  // ============================================================
  // status, error monitor, read buffers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      err_flag                   <= 1'b0;
      prot_flag                  <= 1'b0;
      error_address_monitor_low  <= 16'h0000;
      error_address_monitor_high <= '0;
    end else if (ev_err) begin
      err_flag  <= 1'b1;
      prot_flag <= blocked;
      // erase failures log the block start, others the word address
      error_address_monitor_low  <= (command_code == flash_seq_pkg::cmd_block_erase)
                                    ? {cur_addr[15:10], 10'h000} : cur_addr[15:0];
      error_address_monitor_high <= (WIDE != 0) ? HW'({cur_addr[31:25], 4'h0, cur_addr[20:16]})
                                                : HW'(cur_addr[19:16]);
    end else if (go) begin
      err_flag  <= 1'b0;
      prot_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      read_buffer_low  <= 16'h0000;
      read_buffer_high <= 16'h0000;
      read_ready_flag  <= 1'b0;
    end else if (state == flash_seq_pkg::st_run && command_code == flash_seq_pkg::cmd_uid_read) begin
      read_buffer_low  <= {uid_mem[{cur_addr[4:2], 2'b01}], uid_mem[{cur_addr[4:2], 2'b00}]};
      read_buffer_high <= {uid_mem[{cur_addr[4:2], 2'b11}], uid_mem[{cur_addr[4:2], 2'b10}]};
      read_ready_flag  <= 1'b1;
    end else if (rd_done) begin
      read_ready_flag <= 1'b0;
    end
  end

  // ============================================================
  // extra area: window and startup monitors, unique id
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      access_window_start_monitor <= flash_seq_pkg::aw_blank;
      access_window_end_monitor   <= flash_seq_pkg::aw_blank;
      startup_setting_monitor     <= 1'b0;
    end else if (state == flash_seq_pkg::st_run && !stop) begin
      if (command_code == flash_seq_pkg::cmd_window_prg) begin
        access_window_start_monitor <= write_buffer_low[9:0];
        access_window_end_monitor   <= write_buffer_high[9:0];
      end
      if (command_code == flash_seq_pkg::cmd_startup_prg) begin
        startup_setting_monitor <= write_buffer_low[0];
      end
    end
  end

  // uid bytes are factory content; default image is index-derived
  always_comb begin
    for (int k = 0; k < 32; k++) begin
      uid_mem[k] = 8'(k) ^ 8'ha5;
    end
  end

  // ============================================================
  // interrupt: set wins over write-one clear
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~((wr_acc && i_paddr == flash_seq_pkg::off_irq_status) ? i_pwdata[1:0] : 2'h0))
                    | {ev_err, ev_done};
    end
  end
  assign o_irq = |(irq_status & irq_mask);

  // ============================================================
  // read mux
  always_comb begin
    next_rdata = 32'h0;
    // uid window runs to the top of the 8-bit address space
    if (i_paddr >= flash_seq_pkg::off_uid_base) begin
      next_rdata = {24'h0, uid_mem[5'(i_paddr[6:2])]};
    end else begin
      unique case (i_paddr)
        flash_seq_pkg::off_start_low:  next_rdata = {16'h0, start_address_low};
        flash_seq_pkg::off_start_high: next_rdata = 32'(start_address_high);
        flash_seq_pkg::off_end_low:    next_rdata = {16'h0, end_address_low};
        flash_seq_pkg::off_end_high:   next_rdata = 32'(end_address_high);
        flash_seq_pkg::off_wbuf_low:   next_rdata = {16'h0, write_buffer_low};
        flash_seq_pkg::off_wbuf_high:  next_rdata = {16'h0, write_buffer_high};
        flash_seq_pkg::off_rbuf_low:   next_rdata = {16'h0, read_buffer_low};
        flash_seq_pkg::off_rbuf_high:  next_rdata = {16'h0, read_buffer_high};
        flash_seq_pkg::off_cmd:        next_rdata = {29'h0, command_code};
        flash_seq_pkg::off_status:     next_rdata = {28'h0, prot_flag, err_flag, read_ready_flag,
                                                     state == flash_seq_pkg::st_idle};
        flash_seq_pkg::off_err_low:    next_rdata = {16'h0, error_address_monitor_low};
        flash_seq_pkg::off_err_high:   next_rdata = 32'(error_address_monitor_high);
        flash_seq_pkg::off_aw_start:   next_rdata = {22'h0, access_window_start_monitor};
        flash_seq_pkg::off_aw_end:     next_rdata = {22'h0, access_window_end_monitor};
        flash_seq_pkg::off_irq_status: next_rdata = {30'h0, irq_status};
        flash_seq_pkg::off_irq_mask:   next_rdata = {30'h0, irq_mask};
        flash_seq_pkg::off_startup:    next_rdata = {31'h0, startup_setting_monitor};
        default:                       next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= next_rdata;
    end
  end
endmodule

// ### flash_seq_assertions.sv
// port checker for the flash sequencer
// assumes the narrow variant, bound onto every sequencer instance
`timescale 1ns/100ps
module flash_seq_assertions #(
  parameter int             IDW     = 32,
  parameter logic [IDW-1:0] ID_CODE = 32'h5a5a_0001 // arbitrary value
) (
  input wire logic           i_ref_clk,
  input wire logic           i_nrst,
  input wire logic           i_psel,
  input wire logic           i_penable,
  input wire logic           i_pwrite,
  input wire logic [31:0]    o_prdata,
  input wire logic           o_fl_we,
  input wire logic           o_fl_erase,
  input wire logic [31:0]    o_fl_addr,
  input wire logic           i_data_area,
  input wire logic           o_code_read_ok,
  input wire logic [IDW-1:0] i_offered_id,
  input wire logic           o_conn_grant,
  input wire logic           o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  bgo_read_a: assert property (i_data_area |-> o_code_read_ok)
    else $error("code reads blocked during data op");
  code_busy_a: assert property ((o_fl_we || o_fl_erase) && !i_data_area |-> !o_code_read_ok)
    else $error("code reads open during code op");
  word_gap_a: assert property (o_fl_we |=> !o_fl_we [*8])
    else $error("program words too close");
  erase_gap_a: assert property (o_fl_erase |=> !o_fl_erase [*8])
    else $error("erase pulses too close");
  one_op_a: assert property (!(o_fl_we && o_fl_erase))
    else $error("program and erase together");
  narrow_addr_a: assert property (o_fl_we || o_fl_erase |-> o_fl_addr[31:20] == 12'h000)
    else $error("address above bit 19");
  rdata_hold_a: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
    else $error("read data moved without a read");
  bad_id_a: assert property ((i_offered_id != ID_CODE) [*4] |-> !o_conn_grant)
    else $error("grant with wrong code");
  irq_clear_a: assert property ($fell(o_irq) |-> $past(i_psel && i_penable && i_pwrite))
    else $error("interrupt dropped without a write");
endmodule
bind flash_program_erase_sequencer flash_seq_assertions #(.IDW(IDW), .ID_CODE(ID_CODE)) chk_u (
  .i_ref_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .o_prdata, .o_fl_we, .o_fl_erase, .o_fl_addr,
  .i_data_area, .o_code_read_ok, .i_offered_id, .o_conn_grant, .o_irq);

// ### flash_array_model.sv
// behavioural flash array behind the sequencer
// assumes 1 KB blocks; words alias across blocks to keep it small
`timescale 1ns/100ps
module flash_array_model (
  input wire logic        i_ref_clk,
  input wire logic        i_we,
  input wire logic        i_erase,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0]     o_rdata
);
  logic [31:0] mem [256];
  int          n_we = 0;
  int          n_erase = 0;
  initial foreach (mem[k]) mem[k] = 32'hffff_ffff;
  always @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_addr[9:2]] <= i_wdata;
      n_we <= n_we + 1;
    end
    if (i_erase) begin
      // erased cells read all ones, which blank check relies on
      foreach (mem[k]) mem[k] <= 32'hffff_ffff;
      n_erase <= n_erase + 1;
    end
  end
  assign o_rdata = mem[i_addr[9:2]];
endmodule

// ### flash_program_erase_sequencer_test.sv
// register-level test of the flash sequencer over apb
// assumes zero-wait apb and the array model as far side
`timescale 1ns/100ps
module flash_program_erase_sequencer_test;
  localparam logic [31:0] id_val = 32'h5a5a_0001; // arbitrary value
  logic        i_ref_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, i_offered_id = 32'h0;
  logic [31:0] o_prdata, i_fl_rdata, o_fl_addr, o_fl_wdata, rv;
  logic        o_pready, o_pslverr, o_fl_we, o_fl_erase, o_code_read_ok, o_conn_grant, o_irq;
  logic        i_data_area = 1'b0, i_boot_mode = 1'b0, i_dbg_req = 1'b0, i_self_prog = 1'b0;
  int          n_mismatch = 0, compares = 0, base;
  always #50 i_ref_clk = ~i_ref_clk;
  flash_program_erase_sequencer #(.ID_CODE(id_val)) dut_u (
    .i_ref_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .o_fl_we, .o_fl_erase, .o_fl_addr, .o_fl_wdata, .i_fl_rdata, .i_data_area,
    .o_code_read_ok, .i_boot_mode, .i_dbg_req, .i_offered_id, .o_conn_grant, .i_self_prog, .o_irq);
  flash_array_model model_u (.i_ref_clk, .i_we(o_fl_we), .i_erase(o_fl_erase), .i_addr(o_fl_addr),
    .i_wdata(o_fl_wdata), .o_rdata(i_fl_rdata));
  task final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    @(posedge i_ref_clk);
    while (o_pready !== 1'b1) @(posedge i_ref_clk);
    rv = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rv, exp);
  endtask
  task rng(input logic [31:0] s, input logic [31:0] e);
    wr(flash_seq_pkg::off_start_low, {16'h0, s[15:0]});
    wr(flash_seq_pkg::off_start_high, {16'h0, s[31:16]});
    wr(flash_seq_pkg::off_end_low, {16'h0, e[15:0]});
    wr(flash_seq_pkg::off_end_high, {16'h0, e[31:16]});
  endtask
  task wait_rdy;
    repeat (2) @(posedge i_ref_clk);
    for (int t = 0; t < 400; t++) begin
      xfer(flash_seq_pkg::off_status, 1'b0, 32'h0);
      if (rv[flash_seq_pkg::st_ready_bit] === 1'b1) break;
    end
  endtask
  task cmd(input logic [2:0] c);
    wr(flash_seq_pkg::off_cmd, {29'h0, c} | 32'h10);
    wait_rdy();
  endtask
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    rd_chk("aw_start", flash_seq_pkg::off_aw_start, 32'h3ff);
    rd_chk("aw_end", flash_seq_pkg::off_aw_end, 32'h3ff);
    rd_chk("status", flash_seq_pkg::off_status, 32'h1);
    rng(32'hffff_ffff, 32'hffff_ffff);
    rd_chk("sa_low", flash_seq_pkg::off_start_low, 32'hffff);
    rd_chk("sa_high", flash_seq_pkg::off_start_high, 32'h0f);
    rd_chk("ea_high", flash_seq_pkg::off_end_high, 32'h0f);
    wr(8'h44, 32'h1);
    rd_chk("unmapped", 8'h44, 32'h0);
    for (int u = 0; u < 32; u++) begin
      // ids are read-only, so a write must not stick
      wr(flash_seq_pkg::off_uid_base + 8'(4 * u), 32'h0);
      rd_chk("uid", flash_seq_pkg::off_uid_base + 8'(4 * u), {24'h0, 8'(u) ^ 8'ha5});
    end
    i_offered_id <= id_val;
    i_dbg_req <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk("grant_dbg", {31'h0, o_conn_grant}, 32'h1);
    i_dbg_req <= 1'b0;
    i_boot_mode <= 1'b1;
    i_offered_id <= ~id_val;
    repeat (6) @(posedge i_ref_clk);
    chk("grant_bad", {31'h0, o_conn_grant}, 32'h0);
    i_boot_mode <= 1'b0;
    i_data_area <= 1'b1;
    wr(flash_seq_pkg::off_wbuf_low, 32'h1234);
    wr(flash_seq_pkg::off_wbuf_high, 32'h5678);
    rng(32'h100, 32'h104);
    base = model_u.n_we;
    wr(flash_seq_pkg::off_cmd, 32'h11);
    xfer(flash_seq_pkg::off_status, 1'b0, 32'h0);
    chk("busy", {31'h0, rv[0]}, 32'h0);
    chk("bgo", {31'h0, o_code_read_ok}, 32'h1);
    wait_rdy();
    chk("words", 32'(model_u.n_we - base), 32'h2);
    rd_chk("irq_st", flash_seq_pkg::off_irq_status, 32'h1);
    chk("masked", {31'h0, o_irq}, 32'h0);
    wr(flash_seq_pkg::off_irq_mask, 32'h3);
    @(negedge i_ref_clk);
    chk("irq_on", {31'h0, o_irq}, 32'h1);
    wr(flash_seq_pkg::off_irq_status, 32'h1);
    @(negedge i_ref_clk);
    chk("irq_off", {31'h0, o_irq}, 32'h0);
    rng(32'h100, 32'h100);
    cmd(3'h2);
    chk("blank_err", {31'h0, rv[flash_seq_pkg::st_err_bit]}, 32'h1);
    rd_chk("err_low", flash_seq_pkg::off_err_low, 32'h100);
    base = model_u.n_erase;
    cmd(3'h3);
    chk("erases", 32'(model_u.n_erase - base), 32'h1);
    wr(flash_seq_pkg::off_wbuf_low, 32'h11);
    wr(flash_seq_pkg::off_wbuf_high, 32'h20);
    cmd(3'h6);
    rd_chk("aw_start", flash_seq_pkg::off_aw_start, 32'h11);
    rd_chk("aw_end", flash_seq_pkg::off_aw_end, 32'h20);
    i_self_prog <= 1'b1;
    i_data_area <= 1'b0;
    rng(32'h6000, 32'h6000);
    base = model_u.n_we;
    cmd(3'h1);
    chk("in_window", 32'(model_u.n_we - base), 32'h1);
    rng(32'h1_8000, 32'h1_8000);
    cmd(3'h1);
    chk("refused", 32'(model_u.n_we - base), 32'h1);
    chk("prot", {31'h0, rv[flash_seq_pkg::st_prot_bit]}, 32'h1);
    rd_chk("err_high", flash_seq_pkg::off_err_high, 32'h1);
    rd_chk("err_low", flash_seq_pkg::off_err_low, 32'h8000);
    i_self_prog <= 1'b0;
    cmd(3'h4);
    chk("rd_ready", {31'h0, rv[flash_seq_pkg::st_rdrdy_bit]}, 32'h1);
    rd_chk("rbuf_low", flash_seq_pkg::off_rbuf_low, 32'ha4a5);
    rd_chk("rbuf_high", flash_seq_pkg::off_rbuf_high, 32'ha6a7);
    wr(flash_seq_pkg::off_cmd, 32'h40);
    xfer(flash_seq_pkg::off_status, 1'b0, 32'h0);
    chk("rd_done", {31'h0, rv[flash_seq_pkg::st_rdrdy_bit]}, 32'h0);
    cmd(3'h5);
    chk("startup", {31'h0, rv[0]}, 32'h1);
    rd_chk("startup_mon", flash_seq_pkg::off_startup, 32'h1);
    wr(flash_seq_pkg::off_irq_status, 32'h3);
    i_data_area <= 1'b1;
    rng(32'h100, 32'h1fc);
    base = model_u.n_we;
    wr(flash_seq_pkg::off_cmd, 32'h11);
    repeat (30) @(posedge i_ref_clk);
    wr(flash_seq_pkg::off_cmd, 32'h20);
    wait_rdy();
    chk("stopped", {31'h0, model_u.n_we - base < 64}, 32'h1);
    xfer(flash_seq_pkg::off_irq_status, 1'b0, 32'h0);
    chk("stop_irq", {31'h0, rv[0]}, 32'h1);
    final_report();
  end
endmodule
